// File: common/tcx_cfg.svh
// offsets, field positions, reset values and codes of the compare-output timer
`ifndef TCX_CFG_SVH
`define TCX_CFG_SVH

// register offsets (word index on the plain register port)
`define TCX_OFF_CTRL 4'h0
`define TCX_OFF_FORCE 4'h1
`define TCX_OFF_COUNT 4'h2
`define TCX_OFF_CMPA 4'h3
`define TCX_OFF_CMPB 4'h4
`define TCX_OFF_CAPT 4'h5
`define TCX_OFF_FLAGS 4'h6
`define TCX_OFF_PORT 4'h7
`define TCX_OFF_STATE 4'h8

// control register fields
`define TCX_CTRL_MODE_LSB 0
`define TCX_CTRL_MODE_MSB 3
`define TCX_CTRL_CSEL_LSB 4
`define TCX_CTRL_CSEL_MSB 6
`define TCX_CTRL_ACTA_LSB 8
`define TCX_CTRL_ACTA_MSB 9
`define TCX_CTRL_ACTB_LSB 10
`define TCX_CTRL_ACTB_MSB 11

// force register bits
`define TCX_FORCE_A 0
`define TCX_FORCE_B 1

// flag register bits
`define TCX_FLAG_OVF 0
`define TCX_FLAG_CMPA 1
`define TCX_FLAG_CMPB 2
`define TCX_FLAG_CAPT 3

// port register bits
`define TCX_PORT_OUTA 0
`define TCX_PORT_OUTB 1
`define TCX_PORT_DIRA 2
`define TCX_PORT_DIRB 3

// waveform mode codes
`define TCX_MODE_NORMAL 4'h0
`define TCX_MODE_CTC_CMPA 4'h4
`define TCX_MODE_CTC_CAPT 4'hc

// clock select codes
`define TCX_CSEL_STOP 3'h0
`define TCX_CSEL_DIV1 3'h1
`define TCX_CSEL_DIV8 3'h2
`define TCX_CSEL_DIV64 3'h3
`define TCX_CSEL_DIV256 3'h4
`define TCX_CSEL_DIV1024 3'h5

// prescaler masks: tick when all masked low bits are ones
`define TCX_PRE_MASK8 10'h007
`define TCX_PRE_MASK64 10'h03f
`define TCX_PRE_MASK256 10'h0ff
`define TCX_PRE_MASK1024 10'h3ff

// counter extremes and reset values
`define TCX_COUNT_MAX 16'hffff
`define TCX_COUNT_VALUE_A 16'h0000
`define TCX_RST_WORD 16'h0000
`define TCX_RST_CTRL 16'h0000
`define TCX_RST_FLAGS 4'h0
`define TCX_RST_PORT 4'h0

`endif

// File: common/tcx_pkg.sv
// types shared by the compare-output timer
package tcx_pkg;

  // 16-bit timer word
  typedef logic [15:0] tcx_word_t;

  // register index on the plain register port
  typedef logic [3:0] tcx_addr_t;

  // compare output action, in field order 0..3
  typedef enum logic [1:0] {
    TCX_ACT_NONE,
    TCX_ACT_TOGGLE,
    TCX_ACT_CLEAR,
    TCX_ACT_SET
  } tcx_act_t;

endpackage : tcx_pkg

// File: hw/tcx_timer.sv
// 16-bit timer with two compare-output units, normal and clear-on-match modes
`timescale 1ns/100ps
`include "tcx_cfg.svh"

module tcx_timer (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // register port
  input wire tcx_pkg::tcx_addr_t regAddr,
  input wire tcx_pkg::tcx_word_t regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output tcx_pkg::tcx_word_t regRdData,
  // interrupt service acknowledges from the interrupt controller
  input wire logic ovfIntAck,
  input wire logic cmpAIntAck,
  input wire logic cmpBIntAck,
  input wire logic captIntAck,
  // capture event pin
  input wire logic captPinIn,
  // flag levels toward the interrupt controller
  output logic [3:0] flagsOut,
  // compare output pins
  output logic compareOutputAOut,
  output logic compareOutputAOen_n,
  output logic compareOutputBOut,
  output logic compareOutputBOen_n
);
  import tcx_pkg::*;

  // next state after one action; also used for force
  function automatic logic apply_action(input logic [1:0] act, input logic cur);
    logic res;
    res = cur;
    case (tcx_act_t'(act))
      TCX_ACT_NONE: res = cur;
      TCX_ACT_TOGGLE: res = ~cur;
      TCX_ACT_CLEAR: res = 1'b0;
      TCX_ACT_SET: res = 1'b1;
      default: res = cur;
    endcase
    return res;
  endfunction : apply_action

  // software visible registers and internal state flops
  logic [3:0] waveMode_ff;
  logic [2:0] clkSel_ff;
  logic [1:0] actionA_ff;
  logic [1:0] actionB_ff;
  tcx_word_t count_ff;
  tcx_word_t cmpA_ff;
  tcx_word_t cmpB_ff;
  tcx_word_t capt_ff;
  logic [3:0] flags_ff;
  logic [3:0] port_ff;
  logic stateA_ff;
  logic stateB_ff;
  logic blockMatch_ff;
  logic [9:0] preCnt_ff;
  logic captSync1_ff;
  logic captSync2_ff;
  logic captPrev_ff;
  tcx_word_t regRdData_ff;
  logic pinAOut_ff;
  logic pinAOen_n_ff;
  logic pinBOut_ff;
  logic pinBOen_n_ff;

  // decoded accesses
  logic wrCtrl;
  logic wrForce;
  logic wrCount;
  logic wrCmpA;
  logic wrCmpB;
  logic wrCapt;
  logic wrFlags;
  logic wrPort;

  assign wrCtrl = regWrEn && (regAddr == `TCX_OFF_CTRL);
  assign wrForce = regWrEn && (regAddr == `TCX_OFF_FORCE);
  assign wrCount = regWrEn && (regAddr == `TCX_OFF_COUNT);
  assign wrCmpA = regWrEn && (regAddr == `TCX_OFF_CMPA);
  assign wrCmpB = regWrEn && (regAddr == `TCX_OFF_CMPB);
  assign wrCapt = regWrEn && (regAddr == `TCX_OFF_CAPT);
  assign wrFlags = regWrEn && (regAddr == `TCX_OFF_FLAGS);
  assign wrPort = regWrEn && (regAddr == `TCX_OFF_PORT);

  // control register: mode, clock select, both action fields
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      waveMode_ff <= 4'(`TCX_RST_CTRL);
      clkSel_ff <= `TCX_CSEL_STOP;
      actionA_ff <= 2'h0;
      actionB_ff <= 2'h0;
    end else if (wrCtrl) begin
      waveMode_ff <= regWrData[`TCX_CTRL_MODE_MSB:`TCX_CTRL_MODE_LSB];
      clkSel_ff <= regWrData[`TCX_CTRL_CSEL_MSB:`TCX_CTRL_CSEL_LSB];
      actionA_ff <= regWrData[`TCX_CTRL_ACTA_MSB:`TCX_CTRL_ACTA_LSB];
      actionB_ff <= regWrData[`TCX_CTRL_ACTB_MSB:`TCX_CTRL_ACTB_LSB];
    end
  end

  // prescaler, counting the system clock, held at zero while the clock is stopped
  logic timerTick;
  always_ff @(posedge ref_clk) begin
    if (reset || clkSel_ff == `TCX_CSEL_STOP) begin
      preCnt_ff <= 10'h000;
    end else begin
      preCnt_ff <= preCnt_ff + 10'h001;
    end
  end

  // divide factor picked from the clock select code
  always_comb begin
    case (clkSel_ff)
      `TCX_CSEL_DIV1: timerTick = 1'b1;
      `TCX_CSEL_DIV8: timerTick = (preCnt_ff & `TCX_PRE_MASK8) == `TCX_PRE_MASK8;
      `TCX_CSEL_DIV64: timerTick = (preCnt_ff & `TCX_PRE_MASK64) == `TCX_PRE_MASK64;
      `TCX_CSEL_DIV256: timerTick = (preCnt_ff & `TCX_PRE_MASK256) == `TCX_PRE_MASK256;
      `TCX_CSEL_DIV1024: timerTick = (preCnt_ff & `TCX_PRE_MASK1024) == `TCX_PRE_MASK1024;
      default: timerTick = 1'b0;
    endcase
  end

  // mode decode; unlisted modes count like normal mode
  logic modeCtcA;
  logic modeCtcCapt;
  tcx_word_t topValue;
  assign modeCtcA = (waveMode_ff == `TCX_MODE_CTC_CMPA);
  assign modeCtcCapt = (waveMode_ff == `TCX_MODE_CTC_CAPT);
  // top comes from cmpA in mode 4, capture value in mode 12
  assign topValue = modeCtcCapt ? capt_ff : cmpA_ff;

  // raw comparator outputs; all but atMax gated by the write block
  logic matchA;
  logic matchB;
  logic matchTop;
  logic atMax;
  // a count write masks the A, B and top compares of the following tick, not atMax
  assign matchA = timerTick && !blockMatch_ff && (count_ff == cmpA_ff);
  assign matchB = timerTick && !blockMatch_ff && (count_ff == cmpB_ff);
  // top is an equality test, so a top below the count is passed by
  assign matchTop = timerTick && !blockMatch_ff && (modeCtcA || modeCtcCapt)
                    && (count_ff == topValue);
  assign atMax = timerTick && (count_ff == `TCX_COUNT_MAX);

  // block stays armed while stopped, until a tick consumes it
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      blockMatch_ff <= 1'b0;
    end else if (wrCount) begin
      blockMatch_ff <= 1'b1;
    end else if (timerTick) begin
      blockMatch_ff <= 1'b0;
    end
  end

  // counter; only the mode and clock select fields reach this process
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      count_ff <= `TCX_RST_WORD;
    end else if (wrCount) begin
      // software write wins at any time
      count_ff <= regWrData;
    end else if (matchTop) begin
      // clear to value_a on top match
      count_ff <= `TCX_COUNT_VALUE_A;
    end else if (timerTick) begin
      // up count, wraps from max to value_a
      // a missed top also wraps through max
      count_ff <= count_ff + 16'h0001;
    end
  end

  // compare value registers A and B; no double buffering here
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cmpA_ff <= `TCX_RST_WORD;
      cmpB_ff <= `TCX_RST_WORD;
    end else begin
      if (wrCmpA) begin
        cmpA_ff <= regWrData;
      end
      if (wrCmpB) begin
        cmpB_ff <= regWrData;
      end
    end
  end

  // capture pin synchroniser; first stage feeds only the second
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      captSync1_ff <= 1'b0;
      captSync2_ff <= 1'b0;
      captPrev_ff <= 1'b0;
    end else begin
      captSync1_ff <= captPinIn;
      captSync2_ff <= captSync1_ff;
      captPrev_ff <= captSync2_ff;
    end
  end

  // capture depends on the mode only, never on the action fields
  logic captEvent;
  assign captEvent = captSync2_ff && !captPrev_ff && !modeCtcCapt;

  // capture register; a software write loses to a simultaneous capture
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      capt_ff <= `TCX_RST_WORD;
    end else if (captEvent) begin
      capt_ff <= count_ff;
    end else if (wrCapt) begin
      capt_ff <= regWrData;
    end
  end

  // flag set terms
  logic [3:0] flagSet;
  logic [3:0] flagClr;
  always_comb begin
    flagSet = 4'h0;
    // set as the count passes max into zero
    // a top of ffff still passes max into zero, so the flag sets there too
    flagSet[`TCX_FLAG_OVF] = atMax;
    // top match in mode 4 sets cmpA flag via the A comparator
    flagSet[`TCX_FLAG_CMPA] = matchA;
    flagSet[`TCX_FLAG_CMPB] = matchB;
    // top match in mode 12 sets the capture flag
    flagSet[`TCX_FLAG_CAPT] = captEvent || (matchTop && modeCtcCapt);
    flagClr = wrFlags ? regWrData[3:0] : 4'h0;
    // servicing the overflow clears its flag
    flagClr[`TCX_FLAG_OVF] = flagClr[`TCX_FLAG_OVF] | ovfIntAck;
    flagClr[`TCX_FLAG_CMPA] = flagClr[`TCX_FLAG_CMPA] | cmpAIntAck;
    flagClr[`TCX_FLAG_CMPB] = flagClr[`TCX_FLAG_CMPB] | cmpBIntAck;
    flagClr[`TCX_FLAG_CAPT] = flagClr[`TCX_FLAG_CAPT] | captIntAck;
  end

  // sticky flags, write one to clear; a set in the same cycle wins
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      flags_ff <= `TCX_RST_FLAGS;
    end else begin
      flags_ff <= (flags_ff & ~flagClr) | flagSet;
    end
  end

  // force strobes; modes served here are all non-PWM
  logic forceA;
  logic forceB;
  assign forceA = wrForce && regWrData[`TCX_FORCE_A];
  assign forceB = wrForce && regWrData[`TCX_FORCE_B];

  // compare output state registers
  // reset clears both states
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      stateA_ff <= 1'b0;
      stateB_ff <= 1'b0;
    end else begin
      // action read at match time, so a new value waits for a match
      // force only moves the state, no flag, no counter change
      // force lets software preset the level before the pin drives
      if (matchA || forceA) begin
        stateA_ff <= apply_action(actionA_ff, stateA_ff);
      end
      if (matchB || forceB) begin
        stateB_ff <= apply_action(actionB_ff, stateB_ff);
      end
    end
  end

  // general port register: output values and direction bits
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      port_ff <= `TCX_RST_PORT;
    end else if (wrPort) begin
      port_ff <= regWrData[3:0];
    end
  end

  // pin drivers, registered so outputs come from flops
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pinAOut_ff <= 1'b0;
      pinBOut_ff <= 1'b0;
      pinAOen_n_ff <= 1'b1;
      pinBOen_n_ff <= 1'b1;
    end else begin
      // any nonzero action bit takes the pin over
      pinAOut_ff <= (actionA_ff != 2'h0) ? stateA_ff : port_ff[`TCX_PORT_OUTA];
      pinBOut_ff <= (actionB_ff != 2'h0) ? stateB_ff : port_ff[`TCX_PORT_OUTB];
      // direction stays with the port bit even under override
      pinAOen_n_ff <= ~port_ff[`TCX_PORT_DIRA];
      pinBOen_n_ff <= ~port_ff[`TCX_PORT_DIRB];
    end
  end

  // read mux; unmapped offsets read zero
  tcx_word_t rdMux;
  always_comb begin
    case (regAddr)
      `TCX_OFF_CTRL: rdMux = {4'h0, actionB_ff, actionA_ff, 1'b0, clkSel_ff, waveMode_ff};
      `TCX_OFF_COUNT: rdMux = count_ff;
      `TCX_OFF_CMPA: rdMux = cmpA_ff;
      `TCX_OFF_CMPB: rdMux = cmpB_ff;
      `TCX_OFF_CAPT: rdMux = capt_ff;
      `TCX_OFF_FLAGS: rdMux = {12'h000, flags_ff};
      `TCX_OFF_PORT: rdMux = {12'h000, port_ff};
      `TCX_OFF_STATE: rdMux = {14'h0000, stateB_ff, stateA_ff};
      default: rdMux = 16'h0000;
    endcase
  end

  // read data stands one cycle after the strobe, zero otherwise
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      regRdData_ff <= 16'h0000;
    end else if (regRdEn) begin
      regRdData_ff <= rdMux;
    end else begin
      regRdData_ff <= 16'h0000;
    end
  end

  // outputs straight from flops
  assign regRdData = regRdData_ff;
  assign flagsOut = flags_ff;
  assign compareOutputAOut = pinAOut_ff;
  assign compareOutputAOen_n = pinAOen_n_ff;
  assign compareOutputBOut = pinBOut_ff;
  assign compareOutputBOen_n = pinBOen_n_ff;

endmodule : tcx_timer

// File: tb/tcx_pin_load.sv
// external load on compare output pin A
`timescale 1ns/100ps
module tcx_pin_load (
  // pin as driven by the timer
  input wire logic pinOut,
  input wire logic pinOen_n,
  // level seen by the load
  output logic pinLevel
);
  // visible only when driven
  // weak pull-down: a released pin must not keep showing the last value
  assign pinLevel = pinOen_n ? 1'b0 : pinOut;
endmodule : tcx_pin_load

// File: tb/tcx_timer_monitor.sv
// port assertions for the compare-output timer
`timescale 1ns/100ps
module tcx_timer_monitor (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // register port
  input wire tcx_pkg::tcx_addr_t regAddr,
  input wire tcx_pkg::tcx_word_t regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire tcx_pkg::tcx_word_t regRdData,
  input wire logic ovfIntAck,
  // flags and pins
  input wire logic [3:0] flagsOut,
  input wire logic compareOutputAOut,
  input wire logic compareOutputAOen_n,
  input wire logic compareOutputBOut,
  input wire logic compareOutputBOen_n
);
  import tcx_pkg::*;
  logic [11:0] ctrlShadow_ff;
  // control shadow, so actions are known from the ports alone
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctrlShadow_ff <= 12'h000;
    end else if (regWrEn && regAddr == 4'h0) begin
      ctrlShadow_ff <= regWrData[11:0];
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  AST_RST_IDLE: assert property ($fell(reset) |-> !compareOutputAOut && compareOutputAOen_n
    && compareOutputBOen_n && flagsOut == 4'h0) else $error("outputs not idle after reset");
  AST_OEN_DIR: assert property (regWrEn && regAddr == 4'h7 |-> ##2
    compareOutputAOen_n == !$past(regWrData[2], 2)) else $error("enable not from direction");
  AST_SRC_PORT: assert property (regWrEn && regAddr == 4'h7 && ctrlShadow_ff[9:8] == 2'h0
    ##1 !(regWrEn && regAddr == 4'h0) |=> compareOutputAOut == $past(regWrData[0], 2))
    else $error("pin not from port value");
  AST_FORCE_SET: assert property (regWrEn && regAddr == 4'h1 && regWrData[0]
    && ctrlShadow_ff[9:8] == 2'h3 ##1 !(regWrEn && regAddr == 4'h0) |=> compareOutputAOut)
    else $error("forced set missing on A");
  AST_FORCE_CLR: assert property (regWrEn && regAddr == 4'h1 && regWrData[0]
    && ctrlShadow_ff[9:8] == 2'h2 ##1 !(regWrEn && regAddr == 4'h0) |=> !compareOutputAOut)
    else $error("forced clear missing on A");
  AST_FORCE_B: assert property (regWrEn && regAddr == 4'h1 && regWrData[1]
    && ctrlShadow_ff[11:10] == 2'h3 ##1 !(regWrEn && regAddr == 4'h0) |=> compareOutputBOut)
    else $error("forced set missing on B");
  AST_OVF_HOLD: assert property ($fell(flagsOut[0]) |-> $past(ovfIntAck)
    || $past(regWrEn && regAddr == 4'h6 && regWrData[0])) else $error("overflow flag lost");
  AST_CNT_STEP: assert property (regRdEn && regAddr == 4'h2 && ctrlShadow_ff[6:0] == 7'h10
    ##1 !regWrEn ##1 regRdEn && regAddr == 4'h2 |=> regRdData == $past(regRdData, 2) + 16'h0002)
    else $error("count not stepping by one");
endmodule : tcx_timer_monitor
bind tcx_timer tcx_timer_monitor u_mon (.ref_clk, .reset, .regAddr, .regWrData, .regWrEn,
  .regRdEn, .regRdData, .ovfIntAck, .flagsOut, .compareOutputAOut, .compareOutputAOen_n,
  .compareOutputBOut, .compareOutputBOen_n);

// File: tb/tcx_timer_tb.sv
// self-checking bench for the compare-output timer
`timescale 1ns/100ps
module tcx_timer_tb;
  import tcx_pkg::*;
  // stimulus and observed signals
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  tcx_addr_t regAddr = 4'h0;
  tcx_word_t regWrData = 16'h0000;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  logic ovfIntAck = 1'b0;
  tcx_word_t regRdData;
  logic [3:0] flagsOut;
  logic pinAOut, pinAOen_n, pinBOut, pinBOen_n, pinA;
  int fail_count = 0;
  int n_compared = 0;
  int cyc = 0;
  int n;
  tcx_word_t rv, rv2;
  tcx_word_t cmpTab [3] = '{16'h0003, 16'h0000, 16'h0000};
  int divTab [3] = '{1, 8, 64};
  logic [1:0] actTab [5] = '{2'h2, 2'h1, 2'h0, 2'h1, 2'h3};
  logic stTab [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
  logic pinTab [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1};

  // 200 MHz clock
  always #2.5 ref_clk = ~ref_clk;

  tcx_timer u_dut (.ref_clk, .reset, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData,
    .ovfIntAck, .cmpAIntAck(1'b0), .cmpBIntAck(1'b0), .captIntAck(1'b0), .captPinIn(1'b0),
    .flagsOut, .compareOutputAOut(pinAOut), .compareOutputAOen_n(pinAOen_n),
    .compareOutputBOut(pinBOut), .compareOutputBOen_n(pinBOen_n));
  tcx_pin_load u_load (.pinOut(pinAOut), .pinOen_n(pinAOen_n), .pinLevel(pinA));

  task conclude;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude

  // hang guard, far above the few hundred cycles needed
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      conclude();
    end
  end

  task wr(input tcx_addr_t a, input tcx_word_t d);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge ref_clk);
    regWrEn <= 1'b0;
    @(negedge ref_clk);
  endtask : wr

  task rd(input tcx_addr_t a, output tcx_word_t d);
    @(posedge ref_clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge ref_clk);
    regRdEn <= 1'b0;
    @(negedge ref_clk);
    d = regRdData;
  endtask : rd

  task chk16(input tcx_word_t got, input tcx_word_t exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t word %h expected %h", $time, got, exp);
    end
  endtask : chk16

  task chk1(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t bit %b expected %b", $time, got, exp);
    end
  endtask : chk1

  // cycles between two pin changes; the first two only align, since the
  // source switch and the first match after a preset count are irregular
  task halfp(output int cnt);
    logic v;
    for (int k = 0; k < 3; k++) begin
      v = pinA;
      cnt = 0;
      while (pinA === v && cnt < 5000) begin
        @(negedge ref_clk);
        cnt++;
      end
    end
  endtask : halfp

  // main sequence
  initial begin
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    rd(4'h8, rv);
    chk16(rv, 16'h0000);
    chk1(pinAOen_n, 1'b1);
    rd(4'hf, rv);
    chk16(rv, 16'h0000);
    wr(4'h7, 16'h0001);
    // pin flops follow the port register one cycle later
    @(negedge ref_clk);
    chk1(pinAOut, 1'b1);
    chk1(pinA, 1'b0);
    // preset both states while the pins are still inputs
    wr(4'h0, 16'h0f00);
    wr(4'h1, 16'h0003);
    rd(4'h8, rv);
    chk16(rv, 16'h0003);
    wr(4'h7, 16'h0004);
    @(negedge ref_clk);
    chk1(pinA, 1'b1);
    for (int i = 0; i < 5; i++) begin
      wr(4'h0, {6'h00, actTab[i], 8'h00});
      wr(4'h1, 16'h0001);
      rd(4'h8, rv);
      chk1(rv[0], stTab[i]);
      chk1(pinA, pinTab[i]);
    end
    chk16({12'h000, flagsOut}, 16'h0000);
    rd(4'h2, rv);
    chk16(rv, 16'h0000);
    // normal mode used for the overflow flag, the masked cmpA compare after a count write, and the count step
    wr(4'h3, 16'hfffa);
    wr(4'h2, 16'hfffa);
    wr(4'h0, 16'h0010);
    n = 0;
    while (flagsOut[0] !== 1'b1 && n < 50) begin
      @(negedge ref_clk);
      n++;
    end
    chk1(flagsOut[0], 1'b1);
    chk1(flagsOut[1], 1'b0);
    rd(4'h2, rv);
    rd(4'h2, rv2);
    chk16(rv2 - rv, 16'h0002);
    @(posedge ref_clk);
    ovfIntAck <= 1'b1;
    @(posedge ref_clk);
    ovfIntAck <= 1'b0;
    @(negedge ref_clk);
    chk1(flagsOut[0], 1'b0);
    // toggle on top in mode 4, at three prescaler settings
    for (int i = 0; i < 3; i++) begin
      wr(4'h0, 16'h0000);
      wr(4'h2, 16'hffff);
      wr(4'h3, cmpTab[i]);
      wr(4'h6, 16'h000f);
      wr(4'h0, 16'h0104 | (16'(i + 1) << 4));
      halfp(n);
      chk16(16'(n), 16'(divTab[i] * (1 + cmpTab[i])));
      chk1(flagsOut[1], 1'b1);
    end
    // mode 12: top from the capture value
    wr(4'h0, 16'h0000);
    wr(4'h2, 16'hffff);
    wr(4'h5, 16'h0005);
    wr(4'h3, 16'h0002);
    wr(4'h6, 16'h000f);
    wr(4'h0, 16'h011c);
    halfp(n);
    chk16(16'(n), 16'h0006);
    chk1(flagsOut[3], 1'b1);
    conclude();
  end
endmodule : tcx_timer_tb
